/* include/scp_pkg.sv */
package scp_pkg;

  localparam logic [15:0] ADDR_PANEL_LED_WRITE_CLEAR_READ = 16'h2240;
  localparam logic [15:0] ADDR_PANEL_LED_WRITE_CLEAR_READ_BYTE = 16'h2241;
  localparam logic [15:0] ADDR_SWITCH_READ_ACTIVE_LED_WRITE = 16'h2248;
  localparam logic [15:0] ADDR_SWITCH_READ_ACTIVE_LED_BYTE = 16'h2249;
  localparam logic [15:0] ADDR_SYSTEM_CONTROL_STATUS = 16'h2250;
  localparam logic [15:0] ADDR_SYSTEM_CONTROL_STATUS_HI = 16'h2251;

  // control/status field positions
  localparam int CS_SERIAL_RESET_N = 0;
  localparam int CS_FLOPPY_RESET_N = 1;
  localparam int CS_OPTION_RESET_N = 2;
  localparam int CS_DIAG_CLOCK_SELECT = 3;
  localparam int CS_MASK_PANEL_RESET = 4;
  localparam int CS_LOOPBACK_FLAG_N = 5;
  localparam int CS_COAX_PRESENT_N = 6;
  localparam int CS_RAM_CARD_PRESENT_N = 7;
  localparam int CS_FAN_FAIL_FLAG = 8;
  localparam int CS_PANEL_IRQ_N = 9;
  localparam int CS_OPTION_IRQ_N = 10;
  localparam int CS_FLOPPY_IRQ_N = 11;
  localparam logic [4:0] CS_CTRL_RESET = 5'h00;

  // led port and switch port field positions
  localparam int LED_TEST_WORD_BIT = 10;
  localparam int LED_OFFLINE_WORD_BIT = 11;
  localparam int LED_TEST_BYTE_BIT = 2;
  localparam int LED_OFFLINE_BYTE_BIT = 3;
  localparam int SW_WORD_LSB = 8;
  localparam int SW_BYTE_LSB = 0;

  // button index: online, progload, offline, test (matches switch port order)
  localparam int BTN_ONLINE = 0;
  localparam int BTN_PROGLOAD = 1;
  localparam int BTN_OFFLINE = 2;
  localparam int BTN_TEST = 3;
  localparam int BTN_COUNT = 4;

  // timing
  localparam longint CLK_HZ = 50_000_000;
  localparam longint DIAG_CLK_HZ = 8_000_000;
  localparam longint ACTIVE_LED_MS = 750;
  localparam longint DEBOUNCE_US = 1000;
  localparam int ACTIVE_LED_CYCLES = int'(ACTIVE_LED_MS * CLK_HZ / 1000);
  localparam int DEBOUNCE_CYCLES = int'(DEBOUNCE_US * CLK_HZ / 1_000_000);
  localparam int SYS_RESET_CYCLES = 16;
  // phase accumulator for the diagnostic clock: toggle rate is twice the clock
  localparam int DIAG_ACC_STEP = int'(2 * DIAG_CLK_HZ / 1_000_000);
  localparam int DIAG_ACC_MOD = int'(CLK_HZ / 1_000_000);

  typedef enum logic [2:0] {
    SCP_RST_IDLE = 3'b001,
    SCP_RST_PULSE = 3'b010,
    SCP_RST_HOLD = 3'b100
  } scp_rst_state_t;

endpackage

/* design/scp_top.sv */
`timescale 1ns/1ps
module scp_top
  import scp_pkg::*;
#(
  parameter int ACTIVE_LED_COUNT = ACTIVE_LED_CYCLES,
  parameter int DEBOUNCE_COUNT = DEBOUNCE_CYCLES,
  parameter int SYS_RESET_COUNT = SYS_RESET_CYCLES
)
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic por_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [15:0] io_wdata_in,
  input wire logic io_rd_in,
  input wire logic io_wr_in,
  input wire logic io_byte_in,
  output logic [15:0] io_rdata_out,
  output logic io_rvalid_out,
  input wire logic btn_test_in,
  input wire logic btn_offline_in,
  input wire logic btn_progload_in,
  input wire logic btn_online_in,
  input wire logic overheat_in,
  input wire logic loopback_jumper_n_in,
  input wire logic coax_card_n_in,
  input wire logic ram_card_present_n_in,
  input wire logic option_irq_n_in,
  input wire logic floppy_irq_n_in,
  output logic serial_ctrl_reset_n_out,
  output logic floppy_reset_n_out,
  output logic option_reset_n_out,
  output logic diag_channel_clock_pin_out,
  output logic shared_irq_line_out,
  output logic sys_reset_out,
  output logic led_test_out,
  output logic led_offline_out,
  output logic led_active_out
);

  // ==========================================================================
  // address decode
  // ==========================================================================
  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  logic wr_led_word;
  logic wr_led_byte;
  logic wr_active;
  logic wr_cs;
  logic rd_clear;
  logic rd_sw_word;
  logic rd_sw_byte;
  logic rd_cs_word;
  logic rd_cs_hi_byte;
  logic rd_cs_lo_byte;

  always_comb
  begin
    wr_led_word = 1'b0;
    wr_led_byte = 1'b0;
    wr_active = 1'b0;
    wr_cs = 1'b0;
    if (io_wr_in && addr_is(io_addr_in, ADDR_PANEL_LED_WRITE_CLEAR_READ) && !io_byte_in)
    begin
      wr_led_word = 1'b1;
    end
    else if (io_wr_in && addr_is(io_addr_in, ADDR_PANEL_LED_WRITE_CLEAR_READ_BYTE) && io_byte_in)
    begin
      wr_led_byte = 1'b1;
    end
    else if (io_wr_in && (addr_is(io_addr_in, ADDR_SWITCH_READ_ACTIVE_LED_WRITE)
             || addr_is(io_addr_in, ADDR_SWITCH_READ_ACTIVE_LED_BYTE)))
    begin
      wr_active = 1'b1;
    end
    else if (io_wr_in && addr_is(io_addr_in, ADDR_SYSTEM_CONTROL_STATUS))
    begin
      wr_cs = 1'b1;
    end
  end

  always_comb
  begin
    rd_clear = 1'b0;
    rd_sw_word = 1'b0;
    rd_sw_byte = 1'b0;
    rd_cs_word = 1'b0;
    rd_cs_lo_byte = 1'b0;
    rd_cs_hi_byte = 1'b0;
    if (io_rd_in && (addr_is(io_addr_in, ADDR_PANEL_LED_WRITE_CLEAR_READ)
        || addr_is(io_addr_in, ADDR_PANEL_LED_WRITE_CLEAR_READ_BYTE)))
    begin
      rd_clear = 1'b1;
    end
    else if (io_rd_in && addr_is(io_addr_in, ADDR_SWITCH_READ_ACTIVE_LED_WRITE) && !io_byte_in)
    begin
      rd_sw_word = 1'b1;
    end
    else if (io_rd_in && addr_is(io_addr_in, ADDR_SWITCH_READ_ACTIVE_LED_BYTE) && io_byte_in)
    begin
      rd_sw_byte = 1'b1;
    end
    else if (io_rd_in && addr_is(io_addr_in, ADDR_SYSTEM_CONTROL_STATUS))
    begin
      rd_cs_word = !io_byte_in;
      rd_cs_lo_byte = io_byte_in;
    end
    else if (io_rd_in && addr_is(io_addr_in, ADDR_SYSTEM_CONTROL_STATUS_HI) && io_byte_in)
    begin
      rd_cs_hi_byte = 1'b1;
    end
  end

  // ==========================================================================
  // control bits
  // ==========================================================================
  logic serial_ctrl_reset_n_q;
  logic floppy_reset_n_q;
  logic option_reset_n_q;
  logic diag_clock_select_q;
  logic mask_panel_reset_q;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      serial_ctrl_reset_n_q <= CS_CTRL_RESET[CS_SERIAL_RESET_N];
      floppy_reset_n_q <= CS_CTRL_RESET[CS_FLOPPY_RESET_N];
      option_reset_n_q <= CS_CTRL_RESET[CS_OPTION_RESET_N];
      diag_clock_select_q <= CS_CTRL_RESET[CS_DIAG_CLOCK_SELECT];
      mask_panel_reset_q <= CS_CTRL_RESET[CS_MASK_PANEL_RESET];
    end
    else if (wr_cs)
    begin
      // loopback position and all status bits ignore writes
      serial_ctrl_reset_n_q <= io_wdata_in[CS_SERIAL_RESET_N];
      floppy_reset_n_q <= io_wdata_in[CS_FLOPPY_RESET_N];
      option_reset_n_q <= io_wdata_in[CS_OPTION_RESET_N];
      diag_clock_select_q <= io_wdata_in[CS_DIAG_CLOCK_SELECT];
      mask_panel_reset_q <= io_wdata_in[CS_MASK_PANEL_RESET];
    end
  end

  assign serial_ctrl_reset_n_out = serial_ctrl_reset_n_q;
  assign floppy_reset_n_out = floppy_reset_n_q;
  assign option_reset_n_out = option_reset_n_q;

  // ==========================================================================
  // diagnostic channel clock
  // ==========================================================================
  logic [7:0] diag_acc_q;
  logic diag_clk_q;
  logic [7:0] diag_acc_sum;

  assign diag_acc_sum = diag_acc_q + 8'(DIAG_ACC_STEP);

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      diag_acc_q <= 8'h00;
      diag_clk_q <= 1'b0;
    end
    else if (diag_acc_sum >= 8'(DIAG_ACC_MOD))
    begin
      diag_acc_q <= diag_acc_sum - 8'(DIAG_ACC_MOD);
      diag_clk_q <= !diag_clk_q;
    end
    else
    begin
      diag_acc_q <= diag_acc_sum;
    end
  end

  // withheld (low) while the port runs synchronously
  assign diag_channel_clock_pin_out = diag_clk_q && !diag_clock_select_q;

  // ==========================================================================
  // button debounce and press edges
  // ==========================================================================
  logic [BTN_COUNT-1:0] btn_raw;
  logic [BTN_COUNT-1:0] btn_db_q;
  logic [BTN_COUNT-1:0] btn_db_prev_q;
  logic [BTN_COUNT-1:0] btn_press;

  assign btn_raw = {btn_test_in, btn_offline_in, btn_progload_in, btn_online_in};

  genvar gi;
  generate
    for (gi = 0; gi < BTN_COUNT; gi++)
    begin : g_debounce
      logic [31:0] cnt_q;
      always_ff @(posedge mclk_in)
      begin
        if (por_in)
        begin
          cnt_q <= 32'h0;
          btn_db_q[gi] <= 1'b0;
          btn_db_prev_q[gi] <= 1'b0;
        end
        else
        begin
          btn_db_prev_q[gi] <= btn_db_q[gi];
          if (btn_raw[gi] == btn_db_q[gi])
          begin
            cnt_q <= 32'h0;
          end
          else if (cnt_q >= 32'(DEBOUNCE_COUNT - 1))
          begin
            cnt_q <= 32'h0;
            btn_db_q[gi] <= btn_raw[gi];
          end
          else
          begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
      end
      assign btn_press[gi] = btn_db_q[gi] && !btn_db_prev_q[gi];
    end
  endgenerate

  // ==========================================================================
  // panel leds
  // ==========================================================================
  logic led_test_q;
  logic led_offline_q;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      led_test_q <= 1'b0;
      led_offline_q <= 1'b0;
    end
    else if (wr_led_word)
    begin
      led_test_q <= io_wdata_in[LED_TEST_WORD_BIT];
      led_offline_q <= io_wdata_in[LED_OFFLINE_WORD_BIT];
    end
    else if (wr_led_byte)
    begin
      led_test_q <= io_wdata_in[LED_TEST_BYTE_BIT];
      led_offline_q <= io_wdata_in[LED_OFFLINE_BYTE_BIT];
    end
  end

  assign led_test_out = led_test_q;
  assign led_offline_out = led_offline_q;

  // ==========================================================================
  // panel latches: cleared only by power-up or a clear read
  // ==========================================================================
  logic [BTN_COUNT-1:0] latch_q;
  logic reset_qualified;
  logic [BTN_COUNT-1:0] latch_set;

  assign reset_qualified = (led_offline_q && !mask_panel_reset_q)
    || (!mask_panel_reset_q && btn_db_q[BTN_OFFLINE])
    || btn_db_q[BTN_ONLINE];

  always_comb
  begin
    latch_set = '0;
    latch_set[BTN_TEST] = btn_press[BTN_TEST] && reset_qualified;
    latch_set[BTN_PROGLOAD] = btn_press[BTN_PROGLOAD] && reset_qualified;
    latch_set[BTN_OFFLINE] = btn_press[BTN_OFFLINE];
    latch_set[BTN_ONLINE] = btn_press[BTN_ONLINE];
  end

  always_ff @(posedge mclk_in)
  begin
    if (por_in)
    begin
      latch_q <= '0;
    end
    else
    begin
      // a press in the clear cycle survives the clear
      latch_q <= (rd_clear ? '0 : latch_q) | latch_set;
    end
  end

  // ==========================================================================
  // system reset generation
  // ==========================================================================
  scp_rst_state_t rst_state_q;
  logic [7:0] rst_cnt_q;

  always_ff @(posedge mclk_in)
  begin
    if (por_in)
    begin
      rst_state_q <= SCP_RST_IDLE;
      rst_cnt_q <= 8'h00;
    end
    else
    begin
      case (rst_state_q)
        SCP_RST_IDLE:
        begin
          if (latch_set[BTN_TEST] || latch_set[BTN_PROGLOAD])
          begin
            rst_state_q <= SCP_RST_PULSE;
            rst_cnt_q <= 8'h00;
          end
        end
        SCP_RST_PULSE:
        begin
          if (rst_cnt_q >= 8'(SYS_RESET_COUNT - 1))
          begin
            rst_state_q <= SCP_RST_HOLD;
          end
          else
          begin
            rst_cnt_q <= rst_cnt_q + 8'h01;
          end
        end
        SCP_RST_HOLD:
        begin
          // one reset per set; rearmed once the latch is cleared
          if (!latch_q[BTN_TEST] && !latch_q[BTN_PROGLOAD])
          begin
            rst_state_q <= SCP_RST_IDLE;
          end
        end
        default:
        begin
          rst_state_q <= SCP_RST_IDLE;
        end
      endcase
    end
  end

  assign sys_reset_out = (rst_state_q == SCP_RST_PULSE);

  // ==========================================================================
  // active led retrigger timer
  // ==========================================================================
  logic [31:0] active_cnt_q;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      active_cnt_q <= 32'h0;
    end
    else if (wr_active)
    begin
      active_cnt_q <= 32'(ACTIVE_LED_COUNT);
    end
    else if (active_cnt_q != 32'h0)
    begin
      active_cnt_q <= active_cnt_q - 32'h1;
    end
  end

  assign led_active_out = (active_cnt_q != 32'h0);

  // ==========================================================================
  // status and shared interrupt
  // ==========================================================================
  logic panel_irq_n;
  logic fan_fail_flag;
  logic [15:0] cs_status;

  assign panel_irq_n = !(latch_q[BTN_OFFLINE] || latch_q[BTN_ONLINE]);
  assign fan_fail_flag = overheat_in;

  always_comb
  begin
    cs_status = 16'h0000;
    cs_status[CS_SERIAL_RESET_N] = serial_ctrl_reset_n_q;
    cs_status[CS_FLOPPY_RESET_N] = floppy_reset_n_q;
    cs_status[CS_OPTION_RESET_N] = option_reset_n_q;
    cs_status[CS_DIAG_CLOCK_SELECT] = diag_clock_select_q;
    cs_status[CS_MASK_PANEL_RESET] = mask_panel_reset_q;
    cs_status[CS_LOOPBACK_FLAG_N] = loopback_jumper_n_in;
    cs_status[CS_COAX_PRESENT_N] = coax_card_n_in;
    cs_status[CS_RAM_CARD_PRESENT_N] = ram_card_present_n_in;
    cs_status[CS_FAN_FAIL_FLAG] = fan_fail_flag;
    cs_status[CS_PANEL_IRQ_N] = panel_irq_n;
    cs_status[CS_OPTION_IRQ_N] = option_irq_n_in;
    cs_status[CS_FLOPPY_IRQ_N] = floppy_irq_n_in;
  end

  assign shared_irq_line_out = fan_fail_flag || !panel_irq_n || !option_irq_n_in || !floppy_irq_n_in;

  // ==========================================================================
  // read data
  // ==========================================================================
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic rvalid_q;

  always_comb
  begin
    rdata_d = 16'h0000;
    if (rd_sw_word)
    begin
      rdata_d[SW_WORD_LSB +: BTN_COUNT] = latch_q;
    end
    else if (rd_sw_byte)
    begin
      rdata_d[SW_BYTE_LSB +: BTN_COUNT] = latch_q;
    end
    else if (rd_cs_word)
    begin
      rdata_d = cs_status;
    end
    else if (rd_cs_lo_byte)
    begin
      rdata_d[7:0] = cs_status[7:0];
    end
    else if (rd_cs_hi_byte)
    begin
      rdata_d[7:0] = cs_status[15:8];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= io_rd_in;
    end
  end

  assign io_rdata_out = rdata_q;
  assign io_rvalid_out = rvalid_q;

endmodule // scp_top

/* verification/scp_properties.sv */
`timescale 1ns/1ps
module scp_properties
  import scp_pkg::*;
#(
  parameter int ACTIVE_LED_COUNT = 50
)
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [15:0] io_wdata_in,
  input wire logic io_rd_in,
  input wire logic io_wr_in,
  input wire logic io_byte_in,
  input wire logic io_rvalid_out,
  input wire logic overheat_in,
  input wire logic floppy_irq_n_in,
  input wire logic serial_ctrl_reset_n_out,
  input wire logic floppy_reset_n_out,
  input wire logic option_reset_n_out,
  input wire logic diag_channel_clock_pin_out,
  input wire logic shared_irq_line_out,
  input wire logic sys_reset_out,
  input wire logic led_test_out,
  input wire logic led_offline_out,
  input wire logic led_active_out
);
  // ==========================================
  // active led reference timer
  logic [31:0] led_cnt_q;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      led_cnt_q <= 32'h0;
    else if (io_wr_in && io_addr_in[15:1] == ADDR_SWITCH_READ_ACTIVE_LED_WRITE[15:1])
      led_cnt_q <= 32'(ACTIVE_LED_COUNT);
    else if (led_cnt_q != 32'h0)
      led_cnt_q <= led_cnt_q - 32'h1;
  end

  // ==========================================
  // properties
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence cs_wr;
    io_wr_in && io_addr_in == ADDR_SYSTEM_CONTROL_STATUS;
  endsequence

  sequence rst_pulse;
    sys_reset_out [*8] ##1 sys_reset_out [*8] ##1 !sys_reset_out;
  endsequence

  cs_write_a: assert property (cs_wr |=> serial_ctrl_reset_n_out == $past(io_wdata_in[0]) &&
    floppy_reset_n_out == $past(io_wdata_in[1]) && option_reset_n_out == $past(io_wdata_in[2]))
    else $error("reset outputs do not follow control write");
  cs_reset_a: assert property (disable iff (1'b0) rst_in |=>
    !serial_ctrl_reset_n_out && !floppy_reset_n_out && !option_reset_n_out)
    else $error("reset outputs not asserted by board reset");
  diag_hold_a: assert property (cs_wr ##0 io_wdata_in[CS_DIAG_CLOCK_SELECT] |=> ##1
    !diag_channel_clock_pin_out [*8])
    else $error("diagnostic clock not withheld");
  fan_irq_a: assert property (overheat_in [*4] |-> shared_irq_line_out)
    else $error("overheat not on shared interrupt");
  floppy_irq_a: assert property (!floppy_irq_n_in [*4] |-> shared_irq_line_out)
    else $error("floppy request not on shared interrupt");
  active_led_a: assert property (led_active_out == (led_cnt_q != 32'h0))
    else $error("active led interval wrong");
  sys_pulse_a: assert property ($rose(sys_reset_out) |-> rst_pulse)
    else $error("system reset pulse length wrong");
  led_word_a: assert property (io_wr_in && !io_byte_in && io_addr_in == ADDR_PANEL_LED_WRITE_CLEAR_READ |=>
    led_test_out == $past(io_wdata_in[10]) && led_offline_out == $past(io_wdata_in[11]))
    else $error("word led write wrong");
  led_byte_a: assert property (io_wr_in && io_byte_in && io_addr_in == ADDR_PANEL_LED_WRITE_CLEAR_READ_BYTE |=>
    led_test_out == $past(io_wdata_in[2]) && led_offline_out == $past(io_wdata_in[3]))
    else $error("byte led write wrong");
  rd_answer_a: assert property (io_rvalid_out == $past(io_rd_in))
    else $error("read answer not one cycle after strobe");
endmodule // scp_properties

bind scp_top scp_properties #(.ACTIVE_LED_COUNT(ACTIVE_LED_COUNT)) scp_properties_inst (.mclk_in, .rst_in,
  .io_addr_in, .io_wdata_in, .io_rd_in, .io_wr_in, .io_byte_in, .io_rvalid_out, .overheat_in, .floppy_irq_n_in,
  .serial_ctrl_reset_n_out, .floppy_reset_n_out, .option_reset_n_out, .diag_channel_clock_pin_out,
  .shared_irq_line_out, .sys_reset_out, .led_test_out, .led_offline_out, .led_active_out);

/* verification/scp_host.sv */
`timescale 1ns/1ps
module scp_host
(
  input wire logic mclk_in,
  input wire logic [15:0] io_rdata_in,
  input wire logic io_rvalid_in,
  output logic [15:0] io_addr_out,
  output logic [15:0] io_wdata_out,
  output logic io_rd_out,
  output logic io_wr_out,
  output logic io_byte_out
);
  // ==========================================
  // host bus cycles, driven just after the rising edge
  initial
  begin
    io_addr_out = 16'h0000;
    io_wdata_out = 16'h0000;
    io_rd_out = 1'b0;
    io_wr_out = 1'b0;
    io_byte_out = 1'b0;
  end

  task automatic bus_write(input logic [15:0] a, input logic [15:0] d, input logic b);
    @(posedge mclk_in);
    #1;
    io_addr_out = a;
    io_wdata_out = d;
    io_byte_out = b;
    io_wr_out = 1'b1;
    @(posedge mclk_in);
    #1;
    io_wr_out = 1'b0;
    // released address and data lines carry junk, not the old value; the byte line keeps its value
    io_addr_out = ~a;
    io_wdata_out = ~d;
  endtask

  task automatic bus_read(input logic [15:0] a, input logic b, output logic [15:0] d, output logic v);
    @(posedge mclk_in);
    #1;
    io_addr_out = a;
    io_byte_out = b;
    io_rd_out = 1'b1;
    @(posedge mclk_in);
    #1;
    io_rd_out = 1'b0;
    io_addr_out = ~a;
    d = io_rdata_in;
    v = io_rvalid_in;
  endtask
endmodule // scp_host

/* verification/system_control_and_panel_logic_test.sv */
`timescale 1ns/1ps
module system_control_and_panel_logic_test;
  import scp_pkg::*;
  localparam int LED_N = 50;
  localparam logic [15:0] CS = ADDR_SYSTEM_CONTROL_STATUS;
  localparam logic [15:0] SW = ADDR_SWITCH_READ_ACTIVE_LED_WRITE;
  localparam logic [15:0] PNL = ADDR_PANEL_LED_WRITE_CLEAR_READ;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic [3:0] btn = 4'h0;
  logic ovh = 1'b0, lbj_n = 1'b0, coax_n = 1'b1, ram_n = 1'b0, oirq_n = 1'b1, firq_n = 1'b1;
  logic [15:0] addr, wdata, rdata;
  logic rd, wr, byte_m, rvalid, serial_n, floppy_n, option_n, diag_clk, irq, sysrst, led_t, led_o, led_a;
  int n_mismatch = 0;
  int tests_run = 0;
  int sr_cnt = 0;

  always #10 mclk = ~mclk;
  // counted away from the launching edge so the count never races the state register
  always @(negedge mclk)
  begin
    if (sysrst === 1'b1)
      sr_cnt++;
  end

  scp_host scp_host_inst (.mclk_in(mclk), .io_rdata_in(rdata), .io_rvalid_in(rvalid), .io_addr_out(addr),
    .io_wdata_out(wdata), .io_rd_out(rd), .io_wr_out(wr), .io_byte_out(byte_m));
  scp_top #(.ACTIVE_LED_COUNT(LED_N), .DEBOUNCE_COUNT(4), .SYS_RESET_COUNT(16)) scp_top_inst (.mclk_in(mclk),
    .rst_in(rst), .por_in(por), .io_addr_in(addr), .io_wdata_in(wdata), .io_rd_in(rd), .io_wr_in(wr),
    .io_byte_in(byte_m), .io_rdata_out(rdata), .io_rvalid_out(rvalid), .btn_test_in(btn[BTN_TEST]),
    .btn_offline_in(btn[BTN_OFFLINE]), .btn_progload_in(btn[BTN_PROGLOAD]), .btn_online_in(btn[BTN_ONLINE]),
    .overheat_in(ovh), .loopback_jumper_n_in(lbj_n), .coax_card_n_in(coax_n), .ram_card_present_n_in(ram_n),
    .option_irq_n_in(oirq_n), .floppy_irq_n_in(firq_n), .serial_ctrl_reset_n_out(serial_n),
    .floppy_reset_n_out(floppy_n), .option_reset_n_out(option_n), .diag_channel_clock_pin_out(diag_clk),
    .shared_irq_line_out(irq), .sys_reset_out(sysrst), .led_test_out(led_t), .led_offline_out(led_o),
    .led_active_out(led_a));

  // ==========================================
  // helpers
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr_io(input logic [15:0] a, input logic [15:0] d, input logic b);
    scp_host_inst.bus_write(a, d, b);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic b, input logic [15:0] e);
    logic [15:0] d;
    logic v;
    scp_host_inst.bus_read(a, b, d, v);
    check({15'h0000, v}, 16'h0001);
    check(d, e);
  endtask

  function automatic logic [15:0] exp_cs(input logic [4:0] ctrl, input logic pirq_n);
    return {4'h0, firq_n, oirq_n, pirq_n, ovh, ram_n, coax_n, lbj_n, ctrl};
  endfunction

  task automatic toggles(input int n, output int t);
    logic p;
    t = 0;
    p = diag_clk;
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      if (diag_clk !== p) t++;
      p = diag_clk;
    end
  endtask

  task automatic press(input logic [3:0] hold, input logic [3:0] tap);
    btn = hold;
    cyc(10);
    btn = hold | tap;
    cyc(10);
    btn = 4'h0;
    cyc(30);
  endtask

  // ==========================================
  // scenarios
  task automatic t_ctrl();
    rd_chk(CS, 1'b0, exp_cs(5'h00, 1'b1));
    check({13'h0000, serial_n, floppy_n, option_n}, 16'h0000);
    wr_io(CS, 16'hFFFF, 1'b0);
    check({13'h0000, serial_n, floppy_n, option_n}, 16'h0007);
    rd_chk(CS, 1'b0, exp_cs(5'h1F, 1'b1));
    wr_io(CS, 16'h001C, 1'b0);
    cyc(700);
    check({14'h0000, serial_n, floppy_n}, 16'h0000);
    wr_io(CS, 16'h001F, 1'b0);
    cyc(400);
    wr_io(CS, 16'hFF00, 1'b1);
    rd_chk(CS, 1'b0, exp_cs(5'h00, 1'b1));
    wr_io(CS, 16'h001F, 1'b0);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rd_chk(CS, 1'b0, exp_cs(5'h00, 1'b1));
  endtask

  task automatic t_status();
    logic [15:0] e;
    ovh = 1'b1;
    oirq_n = 1'b0;
    firq_n = 1'b0;
    lbj_n = 1'b1;
    coax_n = 1'b0;
    ram_n = 1'b1;
    cyc(4);
    rd_chk(CS, 1'b0, exp_cs(5'h00, 1'b1));
    e = exp_cs(5'h00, 1'b1);
    rd_chk(CS, 1'b1, {8'h00, e[7:0]});
    rd_chk(ADDR_SYSTEM_CONTROL_STATUS_HI, 1'b1, {8'h00, e[15:8]});
    for (int i = 0; i < 4; i++)
    begin
      ovh = (i == 0);
      oirq_n = (i != 1);
      firq_n = (i != 2);
      cyc(4);
      check(16'(irq), 16'(i < 3));
    end
    lbj_n = 1'b0;
    coax_n = 1'b1;
    ram_n = 1'b0;
  endtask

  task automatic t_diag();
    int t;
    wr_io(CS, 16'h0007, 1'b0);
    toggles(100, t);
    check(16'(t >= 30 && t <= 34), 16'h0001);
    wr_io(CS, 16'h000F, 1'b0);
    cyc(2);
    toggles(50, t);
    check(16'(t), 16'h0000);
    wr_io(CS, 16'h0007, 1'b0);
  endtask

  task automatic t_leds();
    logic [15:0] la[5] = '{PNL, PNL, ADDR_PANEL_LED_WRITE_CLEAR_READ_BYTE, ADDR_PANEL_LED_WRITE_CLEAR_READ_BYTE, PNL};
    logic [15:0] ld[5] = '{16'h0C00, 16'h0400, 16'h0008, 16'h0004, 16'h0000};
    logic lb[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [1:0] le[5] = '{2'b11, 2'b10, 2'b01, 2'b01, 2'b01};
    for (int i = 0; i < 5; i++)
    begin
      wr_io(la[i], ld[i], lb[i]);
      check({14'h0000, led_t, led_o}, {14'h0000, le[i]});
    end
    wr_io(PNL, 16'h0000, 1'b0);
  endtask

  task automatic t_active();
    wr_io(SW, 16'h0000, 1'b0);
    check(16'(led_a), 16'h0001);
    cyc(LED_N - 10);
    wr_io(ADDR_SWITCH_READ_ACTIVE_LED_BYTE, 16'h0000, 1'b1);
    cyc(LED_N - 5);
    check(16'(led_a), 16'h0001);
    cyc(10);
    check(16'(led_a), 16'h0000);
  endtask

  task automatic t_panel();
    sr_cnt = 0;
    // a two-cycle bounce must not reach the latches
    btn = 4'h1 << BTN_OFFLINE;
    cyc(2);
    btn = 4'h0;
    cyc(10);
    rd_chk(SW, 1'b0, 16'h0000);
    press(4'h0, 4'h1 << BTN_ONLINE);
    rd_chk(SW, 1'b0, 16'h0100);
    rd_chk(CS, 1'b0, exp_cs(5'h07, 1'b0));
    check(16'(irq), 16'h0001);
    press(4'h0, 4'h1 << BTN_TEST);
    rd_chk(SW, 1'b0, 16'h0100);
    check(16'(sr_cnt), 16'h0000);
    rd_chk(PNL, 1'b0, 16'h0000);
    cyc(2500);
    rd_chk(ADDR_SWITCH_READ_ACTIVE_LED_BYTE, 1'b1, 16'h0000);
    check(16'(irq), 16'h0000);
    wr_io(PNL, 16'h0800, 1'b0);
    press(4'h0, 4'h1 << BTN_TEST);
    rd_chk(ADDR_SWITCH_READ_ACTIVE_LED_BYTE, 1'b1, 16'h0008);
    check(16'(sr_cnt), 16'h0010);
    rd_chk(ADDR_PANEL_LED_WRITE_CLEAR_READ_BYTE, 1'b1, 16'h0000);
    wr_io(CS, 16'h0017, 1'b0);
    sr_cnt = 0;
    press(4'h1 << BTN_OFFLINE, 4'h1 << BTN_PROGLOAD);
    rd_chk(SW, 1'b0, 16'h0400);
    check(16'(sr_cnt), 16'h0000);
    press(4'h1 << BTN_ONLINE, 4'h1 << BTN_PROGLOAD);
    rd_chk(SW, 1'b0, 16'h0700);
    check(16'(sr_cnt), 16'h0010);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rd_chk(SW, 1'b0, 16'h0700);
    rd_chk(PNL, 1'b0, 16'h0000);
    rd_chk(SW, 1'b0, 16'h0000);
  endtask

  // ==========================================
  // main sequence and watchdog
  initial
  begin
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    por = 1'b0;
    t_ctrl();
    t_status();
    t_diag();
    t_leds();
    t_active();
    t_panel();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end
endmodule // system_control_and_panel_logic_test
